//--- hdl/sw_time_logic.sv
// Switched output: logic combination, time function, forcing, AXI4-Lite registers
`timescale 1ns/1ps
module sw_time_logic
	import sw_time_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic relay_drive
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic aw_got_r, w_got_r; // Write halves held
	logic [7:0] waddr_r; // Held write address
	logic [31:0] wdat_r; // Held write data
	logic [3:0] wstb_r; // Held byte enables
	logic wr_fire; // One-cycle write execute
	logic wr_ok; // Address is mapped
	logic tick; // Timer time base
	logic [15:0] ctrl_r, st_on_r, st_max_r, don_r, doff_r, fl_on_r, fl_off_r;
	logic force_val_r, force_act_r; // Forced operation
	logic sw_r, l1_r, l2_r, tdis_r; // Stored object values
	logic res1_r, logic_r; // Stage results
	logic res1_nxt, logic_nxt; // Next stage results
	logic sw_tel, l1_tel, l2_tel, tdis_tel, brst; // Write pulses
	logic tel_val; // Telegram value bit
	logic ev, ev_val; // Event into the time function
	tf_state_t state_r; // Time function state
	logic [TIMER_W-1:0] timer_r; // Remaining ticks
	logic [TIMER_W:0] pump_sum; // Remaining plus one period
	logic [TIMER_W-1:0] pump_cap; // Capped pumped time
	logic time_out_r; // Time function output
	logic [1:0] mode; // Configured mode
	logic [1:0] op1, op2; // Stage operations
	logic en1, en2, pump; // Stage enables, pump-up

	assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
	assign op1 = ctrl_r[CTRL_OP1_LSB +: 2];
	assign op2 = ctrl_r[CTRL_OP2_LSB +: 2];
	assign en1 = ctrl_r[CTRL_EN1_BIT];
	assign en2 = ctrl_r[CTRL_EN2_BIT];
	assign pump = ctrl_r[CTRL_PUMP_BIT];

	// Tick divider
	tick_gen #(.CYCLES(TICK_CYC)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// Byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// One combining stage
	function automatic logic stage(input logic [1:0] op, input logic a, input logic b);
		case (op)
			OP_AND: stage = a & b;
			OP_OR: stage = a | b;
			OP_XOR: stage = a ^ b;
			default: stage = a; // Open gate passes switch
		endcase
	endfunction : stage

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	// Take address and data in any order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			waddr_r <= 8'h00;
			wdat_r <= 32'h00000000;
			wstb_r <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				waddr_r <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wdat_r <= wdata;
				wstb_r <= wstrb;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	assign wr_fire = aw_got_r && w_got_r && !bvalid;
	assign wr_ok = (waddr_r[1:0] == 2'h0) && (waddr_r <= ADDR_FL_OFF);
	assign tel_val = wdat_r[0];
	assign sw_tel = wr_fire && waddr_r == ADDR_SW && wstb_r[0];
	assign l1_tel = wr_fire && waddr_r == ADDR_L1 && wstb_r[0];
	assign l2_tel = wr_fire && waddr_r == ADDR_L2 && wstb_r[0];
	assign tdis_tel = wr_fire && waddr_r == ADDR_TDIS && wstb_r[0];
	assign brst = wr_fire && waddr_r == ADDR_CMD && wstb_r[0] && wdat_r[CMD_BRST_BIT];

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Mode, durations and forcing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RST;
			st_on_r <= TIME_RST;
			st_max_r <= ST_MAX_RST;
			don_r <= TIME_RST;
			doff_r <= TIME_RST;
			fl_on_r <= TIME_RST;
			fl_off_r <= TIME_RST;
			force_val_r <= 1'b0;
			force_act_r <= 1'b0;
		end else if (brst) begin
			force_act_r <= 1'b0; // Bus reset drops forcing
		end else if (wr_fire) begin
			case (waddr_r)
				ADDR_CTRL: ctrl_r <= merge16(ctrl_r, wdat_r, wstb_r);
				ADDR_ST_ON: st_on_r <= merge16(st_on_r, wdat_r, wstb_r);
				ADDR_ST_MAX: st_max_r <= merge16(st_max_r, wdat_r, wstb_r);
				ADDR_DON: don_r <= merge16(don_r, wdat_r, wstb_r);
				ADDR_DOFF: doff_r <= merge16(doff_r, wdat_r, wstb_r);
				ADDR_FL_ON: fl_on_r <= merge16(fl_on_r, wdat_r, wstb_r);
				ADDR_FL_OFF: fl_off_r <= merge16(fl_off_r, wdat_r, wstb_r);
				ADDR_FORCE: begin
					if (wstb_r[0]) begin
						force_val_r <= wdat_r[FORCE_VAL_BIT];
						force_act_r <= wdat_r[FORCE_ACT_BIT];
					end
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Logic combination
	// ------------------------------------------------------------
	// Two stages; closed gates swallow the event
	always_comb begin
		logic s, a1, a2, go1, go2;
		s = sw_r;
		a1 = l1_r;
		a2 = l2_r;
		go1 = 1'b0;
		go2 = 1'b0;
		res1_nxt = res1_r;
		logic_nxt = logic_r;
		ev = 1'b0;
		if (sw_tel) begin
			s = tel_val;
			go1 = 1'b1;
		end
		if (l1_tel) begin
			a1 = tel_val;
			go1 = en1 && op1 != OP_GATE;
		end
		if (l2_tel) begin
			a2 = tel_val;
			go2 = en2 && op2 != OP_GATE;
		end
		if (go1) begin
			if (!(en1 && op1 == OP_GATE && !a1)) begin
				res1_nxt = en1 ? stage(op1, s, a1) : s;
				go2 = 1'b1;
			end
		end
		if (go2) begin
			if (!(en2 && op2 == OP_GATE && !a2)) begin
				logic_nxt = en2 ? stage(op2, res1_nxt, a2) : res1_nxt;
				ev = 1'b1;
			end
		end
		ev_val = logic_nxt;
	end

	// Object values and stage results
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_r <= 1'b0;
			l1_r <= 1'b0;
			l2_r <= 1'b0;
			tdis_r <= 1'b0;
			res1_r <= 1'b0;
			logic_r <= 1'b0;
		end else if (brst) begin
			sw_r <= 1'b0;
			res1_r <= 1'b0;
			logic_r <= 1'b0;
		end else begin
			if (sw_tel) begin
				sw_r <= tel_val;
			end
			if (l1_tel) begin
				l1_r <= tel_val;
			end
			if (l2_tel) begin
				l2_r <= tel_val;
			end
			if (tdis_tel) begin
				tdis_r <= tel_val;
			end
			res1_r <= res1_nxt;
			logic_r <= logic_nxt;
		end
	end

	// ------------------------------------------------------------
	// Time function
	// ------------------------------------------------------------
	assign pump_sum = {1'b0, timer_r} + {1'b0, st_on_r};
	assign pump_cap = (pump_sum > {1'b0, st_max_r}) ? st_max_r : pump_sum[TIMER_W-1:0];

	// Staircase, delays and flashing on tick counts
	always_ff @(posedge aclk) begin
		if (!aresetn || brst) begin
			state_r <= TF_IDLE;
			timer_r <= '0;
			time_out_r <= 1'b0;
		end else if (tdis_tel && tel_val) begin
			state_r <= TF_IDLE;
			timer_r <= '0;
		end else if (ev) begin
			if (tdis_r || mode == MODE_NONE) begin
				time_out_r <= ev_val;
				state_r <= TF_IDLE;
				timer_r <= '0;
			end else begin
				case (mode)
					MODE_STAIR: begin
						if (ev_val) begin
							time_out_r <= 1'b1;
							state_r <= TF_STAIR;
							timer_r <= (state_r == TF_STAIR && pump) ? pump_cap : st_on_r;
						end else begin
							time_out_r <= 1'b0;
							state_r <= TF_IDLE;
							timer_r <= '0;
						end
					end
					MODE_DELAY: begin
						if (ev_val) begin
							if (state_r == TF_DOFF) begin
								state_r <= TF_IDLE; // Pending off withdrawn
								timer_r <= '0;
							end else if (!time_out_r || state_r == TF_DON) begin
								state_r <= TF_DON;
								timer_r <= don_r;
							end
						end else begin
							if (state_r == TF_DON) begin
								state_r <= TF_IDLE;
								timer_r <= '0;
							end else if (time_out_r || state_r == TF_DOFF) begin
								state_r <= TF_DOFF;
								timer_r <= doff_r;
							end
						end
					end
					default: begin
						if (ev_val) begin
							time_out_r <= 1'b1;
							state_r <= TF_FON;
							timer_r <= fl_on_r;
						end else begin
							time_out_r <= 1'b0;
							state_r <= TF_IDLE;
							timer_r <= '0;
						end
					end
				endcase
			end
		end else if (tick && state_r != TF_IDLE) begin
			if (timer_r > TIMER_W'(1)) begin
				timer_r <= timer_r - TIMER_W'(1);
			end else begin
				case (state_r)
					TF_DON: begin
						time_out_r <= 1'b1;
						state_r <= TF_IDLE;
					end
					TF_FON: begin
						time_out_r <= 1'b0;
						state_r <= TF_FOFF;
						timer_r <= fl_off_r;
					end
					TF_FOFF: begin
						time_out_r <= 1'b1;
						state_r <= TF_FON;
						timer_r <= fl_on_r;
					end
					default: begin
						time_out_r <= 1'b0;
						state_r <= TF_IDLE;
						timer_r <= '0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Relay and read channel
	// ------------------------------------------------------------
	// Forcing overrides the time function
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relay_drive <= 1'b0;
		end else begin
			relay_drive <= force_act_r ? force_val_r : time_out_r;
		end
	end

	// Register read answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				ADDR_CTRL: rdata <= {16'h0000, ctrl_r};
				ADDR_SW: rdata <= {31'h0, sw_r};
				ADDR_L1: rdata <= {31'h0, l1_r};
				ADDR_L2: rdata <= {31'h0, l2_r};
				ADDR_TDIS: rdata <= {31'h0, tdis_r};
				ADDR_FORCE: rdata <= {30'h0, force_act_r, force_val_r};
				ADDR_ST_ON: rdata <= {16'h0000, st_on_r};
				ADDR_ST_MAX: rdata <= {16'h0000, st_max_r};
				ADDR_DON: rdata <= {16'h0000, don_r};
				ADDR_DOFF: rdata <= {16'h0000, doff_r};
				ADDR_FL_ON: rdata <= {16'h0000, fl_on_r};
				ADDR_FL_OFF: rdata <= {16'h0000, fl_off_r};
				ADDR_STATUS: rdata <= {18'h0, state_r, 5'h00, logic_r, time_out_r, relay_drive};
				ADDR_CMD: rdata <= 32'h00000000;
				default: begin
					rdata <= 32'h00000000;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_DISABLED_PASS: assert property (ev && tdis_r && !brst |=> time_out_r == $past(ev_val))
		else $error("Disabled time function delayed a command");
	AST_STAIR_ON: assert property (ev && ev_val && !tdis_r && mode == MODE_STAIR && !brst
		|=> time_out_r && state_r == TF_STAIR)
		else $error("Staircase did not switch on");
	AST_STAIR_EXPIRE: assert property (state_r == TF_STAIR && tick && timer_r <= 16'h0001
		&& !ev && !brst && !tdis_tel |=> !time_out_r)
		else $error("Staircase did not switch off at expiry");
	AST_PUMP_CAP: assert property (state_r == TF_STAIR && ev && ev_val && pump && !tdis_r
		&& mode == MODE_STAIR && !brst |=> timer_r <= $past(st_max_r))
		else $error("Pumped staircase time above maximum");
	AST_ON_CANCEL: assert property (state_r == TF_DON && ev && !ev_val && !tdis_r
		&& mode == MODE_DELAY && !brst |=> state_r == TF_IDLE && !time_out_r)
		else $error("Off during on-delay did not cancel");
	AST_FORCE_WINS: assert property (force_act_r |=> relay_drive == $past(force_val_r))
		else $error("Forced value not on relay");
	AST_RELAY_FOLLOW: assert property (!force_act_r ##1 !force_act_r
		|-> relay_drive == $past(time_out_r))
		else $error("Relay does not follow time function");
	AST_AND_STAGE: assert property (sw_tel && en1 && op1 == OP_AND && (!en2 || op2 == OP_AND)
		|-> ev && ev_val == (tel_val & l1_r & (!en2 || l2_r)))
		else $error("AND stage wrong");
	AST_OR_STAGE: assert property (sw_tel && en1 && op1 == OP_OR && (!en2 || op2 == OP_OR)
		|-> ev && ev_val == (tel_val | l1_r | (en2 && l2_r)))
		else $error("OR stage wrong");
	AST_XOR_STAGE: assert property (sw_tel && en1 && op1 == OP_XOR && (!en2 || op2 == OP_XOR)
		|-> ev && ev_val == (tel_val ^ l1_r ^ (en2 && l2_r)))
		else $error("XOR stage wrong");
	AST_GATE_BLOCK: assert property (sw_tel && en1 && op1 == OP_GATE && !l1_r |-> !ev)
		else $error("Closed gate passed a switch value");
	AST_LOGIC_KEEP: assert property (brst |=> l1_r == $past(l1_r) && l2_r == $past(l2_r))
		else $error("Bus reset changed logic inputs");

	COV_PUMP: cover property (state_r == TF_STAIR && ev && ev_val && pump);
	COV_DELAY_ON: cover property (state_r == TF_DON ##1 state_r == TF_IDLE && time_out_r);
	COV_FLASH: cover property (state_r == TF_FON ##1 state_r == TF_FOFF);
	COV_FORCE: cover property (force_act_r && force_val_r != time_out_r);
endmodule : sw_time_logic

//--- hdl/tick_gen.sv
// Divider that makes the one-cycle timer tick enable
`timescale 1ns/1ps
module tick_gen
	import sw_time_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick
);
	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	localparam int CW = $clog2(CYCLES + 1); // Counter width
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1); // Terminal count
	logic [CW-1:0] cnt_r; // Cycle counter

	// Count cycles, pulse at wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r >= LAST) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + CW'(1);
			tick <= 1'b0;
		end
	end
endmodule : tick_gen

//--- pkg/sw_time_pkg.sv
// Constants, register map and types of the switched output time logic block
package sw_time_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 25; // System clock period
	localparam int TICK_NS = 1000000; // Timer time base, 1 ms
	localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS; // Cycles per tick
	localparam int TIMER_W = 16; // Width of a tick count
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00; // Mode, operations, enables
	localparam logic [7:0] ADDR_CMD = 8'h04; // Bus reset command
	localparam logic [7:0] ADDR_SW = 8'h08; // Switch telegram
	localparam logic [7:0] ADDR_L1 = 8'h0C; // Logic input one telegram
	localparam logic [7:0] ADDR_L2 = 8'h10; // Logic input two telegram
	localparam logic [7:0] ADDR_TDIS = 8'h14; // Time-disable telegram
	localparam logic [7:0] ADDR_FORCE = 8'h18; // Forced operation
	localparam logic [7:0] ADDR_ST_ON = 8'h1C; // Staircase on-time
	localparam logic [7:0] ADDR_ST_MAX = 8'h20; // Staircase maximum
	localparam logic [7:0] ADDR_DON = 8'h24; // Switch-on delay
	localparam logic [7:0] ADDR_DOFF = 8'h28; // Switch-off delay
	localparam logic [7:0] ADDR_FL_ON = 8'h2C; // Flash on phase
	localparam logic [7:0] ADDR_FL_OFF = 8'h30; // Flash off phase
	localparam logic [7:0] ADDR_STATUS = 8'h34; // Read-only state
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0; // Time mode, two bits
	localparam int CTRL_OP1_LSB = 2; // Stage one operation
	localparam int CTRL_OP2_LSB = 4; // Stage two operation
	localparam int CTRL_EN1_BIT = 6; // Stage one enable
	localparam int CTRL_EN2_BIT = 7; // Stage two enable
	localparam int CTRL_PUMP_BIT = 8; // Pump-up enable
	localparam int FORCE_VAL_BIT = 0; // Forced relay value
	localparam int FORCE_ACT_BIT = 1; // Forcing active
	localparam int CMD_BRST_BIT = 0; // Bus reset
	localparam int STAT_STATE_LSB = 8; // One-hot time state
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_RST = 16'h0000; // No timing, no logic
	localparam logic [15:0] TIME_RST = 16'h000A; // Ten ticks
	localparam logic [15:0] ST_MAX_RST = 16'h0064; // Hundred ticks
	// ------------------------------------------------------------
	// Encodings and types
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_NONE = 2'h0; // Plain switching
	localparam logic [1:0] MODE_STAIR = 2'h1; // Staircase
	localparam logic [1:0] MODE_DELAY = 2'h2; // On/off delays
	localparam logic [1:0] MODE_FLASH = 2'h3; // Flashing
	localparam logic [1:0] OP_AND = 2'h0;
	localparam logic [1:0] OP_OR = 2'h1;
	localparam logic [1:0] OP_XOR = 2'h2;
	localparam logic [1:0] OP_GATE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [5:0] {
		TF_IDLE = 6'b000001, // Steady output
		TF_STAIR = 6'b000010, // Staircase light on
		TF_DON = 6'b000100, // On-delay running
		TF_DOFF = 6'b001000, // Off-delay running
		TF_FON = 6'b010000, // Flash on phase
		TF_FOFF = 6'b100000 // Flash off phase
	} tf_state_t;
endpackage : sw_time_pkg

//--- verif/relay_model.sv
// Relay driver model that counts contact operations
`timescale 1ns/1ps
module relay_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic relay_drive,
	output int toggles
);
	logic last_r; // Previous contact state
	// Count every change of the relay command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_r <= 1'b0;
			toggles <= 0;
		end else begin
			last_r <= relay_drive;
			if (relay_drive !== last_r) toggles <= toggles + 1;
		end
	end
endmodule : relay_model

//--- verif/tb_top.sv
// Self-checking bench for the switched output time logic
`timescale 1ns/1ps
module tb_top;
	import sw_time_pkg::*;
	localparam int TCYC = 4; // Short tick for fast runs
	logic aclk = 1'b0, aresetn = 1'b0; // Clock and reset
	logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Addresses
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd; // Data paths
	logic [3:0] wstrb = 4'h0; // Byte enables
	logic awready, wready, bvalid, arready, rvalid, relay_drive; // Outputs
	logic [1:0] bresp, rresp; // Responses
	int error_cnt = 0, checks = 0, toggles, t0; // Counters
	always #12.5 aclk = ~aclk;
	sw_time_logic #(.TICK_CYC(TCYC)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .relay_drive(relay_drive));
	relay_model relay (.aclk(aclk), .aresetn(aresetn), .relay_drive(relay_drive),
		.toggles(toggles));
	// ------------------------------------------------------------
	// Compare, verdict and bus tasks
	// ------------------------------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: relay %b, wanted %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic give_verdict();
		if (error_cnt == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	// Write one word, hold each channel until taken, then check the response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk_word({30'h0, bresp}, {30'h0, er});
	endtask : wr
	// Read one word and check the response code
	task automatic rdr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk_word({30'h0, rresp}, {30'h0, er});
	endtask : rdr
	// Expected result of one combining stage
	function automatic logic comb(input logic [1:0] op, input logic a, input logic b);
		case (op)
			OP_AND: return a & b;
			OP_OR: return a | b;
			default: return a ^ b;
		endcase
	endfunction : comb
	// Watchdog against a hung handshake
	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		logic e; // Expected logic output
		cyc(12);
		aresetn <= 1'b1;
		rdr(ADDR_CTRL, RESP_OKAY, rd); chk_word(rd, 32'h0);
		rdr(ADDR_ST_MAX, RESP_OKAY, rd); chk_word(rd, 32'h64);
		rdr(ADDR_DON, RESP_OKAY, rd); chk_word(rd, 32'hA);
		rdr(ADDR_STATUS, RESP_OKAY, rd); chk_word(rd, 32'h100);
		rdr(8'h38, RESP_SLVERR, rd); chk_word(rd, 32'h0);
		wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
		// AND, OR, XOR over all inputs; the last arrival decides
		for (int op = 0; op < 3; op++) begin
			wr(ADDR_CTRL, 32'hC0 | (op << 2) | (op << 4), RESP_OKAY);
			for (int v = 0; v < 8; v++) begin
				wr(ADDR_SW, {31'h0, v[0]}, RESP_OKAY);
				wr(ADDR_L1, {31'h0, v[1]}, RESP_OKAY);
				wr(ADDR_L2, {31'h0, v[2]}, RESP_OKAY);
				e = comb(op[1:0], comb(op[1:0], v[0], v[1]), v[2]);
				rdr(ADDR_STATUS, RESP_OKAY, rd);
				chk_word(rd & 32'h7, {29'h0, e, e, e});
			end
		end
		// Gate closed ignores switch, opening alone changes nothing
		wr(ADDR_CTRL, 32'h4C, RESP_OKAY);
		wr(ADDR_L1, 32'h1, RESP_OKAY);
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		wr(ADDR_L1, 32'h0, RESP_OKAY);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(2); chk_bit(relay_drive, 1'b0);
		wr(ADDR_L1, 32'h1, RESP_OKAY);
		cyc(2); chk_bit(relay_drive, 1'b0);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(2); chk_bit(relay_drive, 1'b1);
		// Bus reset keeps the logic input
		wr(ADDR_CMD, 32'h1, RESP_OKAY);
		rdr(ADDR_L1, RESP_OKAY, rd); chk_word(rd, 32'h1);
		cyc(2); chk_bit(relay_drive, 1'b0);
		// Staircase with a retrigger
		wr(ADDR_CTRL, {30'h0, MODE_STAIR}, RESP_OKAY);
		wr(ADDR_ST_ON, 32'h3, RESP_OKAY);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(1); chk_bit(relay_drive, 1'b1);
		cyc(20); chk_bit(relay_drive, 1'b0);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(6);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(6); chk_bit(relay_drive, 1'b1);
		cyc(20); chk_bit(relay_drive, 1'b0);
		// Pump-up adds a period, held to the maximum
		wr(ADDR_CTRL, 32'h101, RESP_OKAY);
		wr(ADDR_ST_ON, 32'h4, RESP_OKAY);
		wr(ADDR_ST_MAX, 32'h6, RESP_OKAY);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(20); chk_bit(relay_drive, 1'b1);
		cyc(5); chk_bit(relay_drive, 1'b0);
		// On-delay, cancelled by an off, then completed
		wr(ADDR_CTRL, {30'h0, MODE_DELAY}, RESP_OKAY);
		wr(ADDR_DON, 32'h3, RESP_OKAY);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(1); chk_bit(relay_drive, 1'b0);
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		cyc(30); chk_bit(relay_drive, 1'b0);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(30); chk_bit(relay_drive, 1'b1);
		// Off-delay of the reset length, restarted by a second off
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		cyc(6);
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		cyc(33); chk_bit(relay_drive, 1'b1);
		cyc(10); chk_bit(relay_drive, 1'b0);
		// Disabled time function switches at once
		wr(ADDR_TDIS, 32'h1, RESP_OKAY);
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(2); chk_bit(relay_drive, 1'b1);
		wr(ADDR_TDIS, 32'h0, RESP_OKAY);
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		cyc(1); chk_bit(relay_drive, 1'b1);
		// Flashing with separate phases
		wr(ADDR_CMD, 32'h1, RESP_OKAY);
		wr(ADDR_CTRL, {30'h0, MODE_FLASH}, RESP_OKAY);
		wr(ADDR_FL_ON, 32'h2, RESP_OKAY);
		wr(ADDR_FL_OFF, 32'h3, RESP_OKAY);
		t0 = toggles;
		wr(ADDR_SW, 32'h1, RESP_OKAY);
		cyc(80); chk_bit(toggles - t0 >= 6, 1'b1);
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		// Forcing overrides the time function
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_FORCE, 32'h3, RESP_OKAY);
		cyc(2); chk_bit(relay_drive, 1'b1);
		wr(ADDR_FORCE, 32'h1, RESP_OKAY);
		wr(ADDR_SW, 32'h0, RESP_OKAY);
		cyc(2); chk_bit(relay_drive, 1'b0);
		give_verdict();
	end
endmodule : tb_top
